// File: rtl/trip_zone_pkg.sv
package trip_zone_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_SOURCE_SELECT = 6'h24;
  localparam logic [5:0] IDX_OUTPUT_ACTION = 6'h28;
  localparam logic [5:0] IDX_INT_ENABLE = 6'h2A;
  localparam logic [5:0] IDX_STATUS_FLAGS = 6'h2B + 6'h01;
  localparam logic [5:0] IDX_FLAG_CLEAR = 6'h2E;

  // Source select layout
  localparam int SEL_CBC_LSB = 0;
  localparam int SEL_OST_LSB = 8;
  localparam int SEL_FIELD_W = 8;

  // Output action layout and codes
  localparam int ACT_A_LSB = 0;
  localparam int ACT_B_LSB = 2;
  localparam int ACT_W = 2;
  localparam logic [1:0] ACT_HIGH_Z = 2'h0;
  localparam logic [1:0] ACT_FORCE_HIGH = 2'h1;
  localparam logic [1:0] ACT_FORCE_LOW = 2'h2;
  localparam logic [1:0] ACT_NO_ACTION = 2'h3;

  // Flag, clear and enable layout
  localparam int FLG_INT = 0;
  localparam int FLG_CBC = 1;
  localparam int FLG_OST = 2;

  // Reset values
  localparam logic [15:0] RST_SOURCE_SELECT = 16'h0000;
  localparam logic [3:0] RST_OUTPUT_ACTION = 4'h0;
  localparam logic [2:1] RST_INT_ENABLE = 2'h0;

  // Bus geometry
  localparam int WB_ADR_W = 8;
  localparam int WB_DAT_W = 32;
  localparam int REG_W = 16;

endpackage

// File: rtl/trip_input_sync.sv
module trip_input_sync
  import trip_zone_pkg::*;
#(
  parameter int WIDTH = 6
)
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Asynchronous pins and their synchronised copy
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] sync_o
);

  typedef struct packed
  {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_type;

  if (WIDTH < 1)
  begin : g_bad_width
    $error("WIDTH must be at least 1");
  end

  sync_state_type s;
  sync_state_type next_s;

  always_comb
  begin
    next_s.meta = pin_i;
    next_s.stable = s.meta;
  end

  // Fault pins idle high, so reset to the inactive level
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s <= '1;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign sync_o = s.stable;

endmodule

// File: rtl/pwm_trip_zone_control.sv
// The register offsets and the Wishbone interface to the registers are this design's own decisions.
module pwm_trip_zone_control
  import trip_zone_pkg::*;
#(
  parameter int TRIP_INPUTS = 6
)
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [WB_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [WB_DAT_W-1:0] wb_dat_i,
  output logic [WB_DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // Fault pins, active low
  input wire logic [TRIP_INPUTS-1:0] fault_trip_input_i,
  // Time base and action qualifier, same clock
  input wire logic ctr_zero_i,
  input wire logic pwm_a_i,
  input wire logic pwm_b_i,
  // Power stage pins
  output logic pwm_output_a_o,
  output logic pwm_output_a_oe_o,
  output logic pwm_output_b_o,
  output logic pwm_output_b_oe_o,
  // Interrupt
  output logic trip_interrupt_o,
  output logic trip_interrupt_pulse_o
);

  if (TRIP_INPUTS < 1 || TRIP_INPUTS > SEL_FIELD_W)
  begin : g_bad_inputs
    $error("TRIP_INPUTS must lie between 1 and 8");
  end

  localparam logic [SEL_FIELD_W-1:0] PIN_MASK =
    SEL_FIELD_W'((1 << TRIP_INPUTS) - 1);

  typedef struct packed
  {
    logic [REG_W-1:0] sel;
    logic [3:0] act;
    logic [2:1] ena;
    logic ost_flag;
    logic cbc_flag;
    logic int_flag;
    logic cbc_cond;
    logic irq_pulse;
    logic a_val;
    logic a_oe;
    logic b_val;
    logic b_oe;
    logic ack;
    logic [WB_DAT_W-1:0] rdata;
  } tz_state_type;

  tz_state_type s;
  tz_state_type next_s;

  logic [TRIP_INPUTS-1:0] trip_sync;
  logic [TRIP_INPUTS-1:0] trip_low;
  logic ost_hit;
  logic cbc_hit;
  logic access;
  logic wr;
  logic [2:0] clr;
  logic trig;
  logic tripped;

  function automatic logic reg_hit(input logic [WB_ADR_W-1:0] adr,
                                   input logic [5:0] idx);
    reg_hit = (adr[WB_ADR_W-1:2] == idx);
  endfunction

  // Returns {output enable, level} for one output
  function automatic logic [1:0] apply_action(input logic [1:0] code,
                                              input logic pwm,
                                              input logic trip);
    logic [1:0] r;
    r = {1'b1, pwm};
    if (trip)
    begin
      case (code)
        ACT_HIGH_Z: r = 2'b00;
        ACT_FORCE_HIGH: r = 2'b11;
        ACT_FORCE_LOW: r = 2'b10;
        default: r = {1'b1, pwm};
      endcase
    end
    apply_action = r;
  endfunction

  trip_input_sync #(
    .WIDTH(TRIP_INPUTS)
  ) u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(fault_trip_input_i),
    .sync_o(trip_sync)
  );

  assign trip_low = ~trip_sync;
  assign ost_hit = |(trip_low & s.sel[SEL_OST_LSB +: TRIP_INPUTS]);
  assign cbc_hit = |(trip_low & s.sel[SEL_CBC_LSB +: TRIP_INPUTS]);
  assign access = wb_cyc_i && wb_stb_i && !s.ack;
  assign wr = access && wb_we_i;
  assign clr = (wr && wb_sel_i[0] && reg_hit(wb_adr_i, IDX_FLAG_CLEAR)) ?
               wb_dat_i[2:0] : 3'h0;
  // Flags cleared by this very write must not keep the interrupt alive
  assign trig = (s.ost_flag && !clr[FLG_OST] && s.ena[FLG_OST])
             || (s.cbc_flag && !clr[FLG_CBC] && s.ena[FLG_CBC]);
  assign tripped = s.ost_flag || s.cbc_cond;

  always_comb
  begin
    next_s = s;
    next_s.ack = access;
    // Trip latches; a new trip wins over a clear
    next_s.ost_flag = ost_hit || (s.ost_flag && !clr[FLG_OST]);
    next_s.cbc_flag = cbc_hit || (s.cbc_flag && !clr[FLG_CBC]);
    if (cbc_hit)
    begin
      next_s.cbc_cond = 1'b1;
    end
    else if (ctr_zero_i)
    begin
      next_s.cbc_cond = 1'b0;
    end
    // Interrupt latch; clearing with an enabled trip flag still set re-fires
    next_s.int_flag = trig || (s.int_flag && !clr[FLG_INT]);
    next_s.irq_pulse = trig && (!s.int_flag || clr[FLG_INT]);
    {next_s.a_oe, next_s.a_val} =
      apply_action(s.act[ACT_A_LSB +: ACT_W], pwm_a_i, tripped);
    {next_s.b_oe, next_s.b_val} =
      apply_action(s.act[ACT_B_LSB +: ACT_W], pwm_b_i, tripped);
    if (wr)
    begin
      if (reg_hit(wb_adr_i, IDX_SOURCE_SELECT))
      begin
        if (wb_sel_i[0])
        begin
          next_s.sel[SEL_CBC_LSB +: SEL_FIELD_W] = wb_dat_i[7:0] & PIN_MASK;
        end
        if (wb_sel_i[1])
        begin
          next_s.sel[SEL_OST_LSB +: SEL_FIELD_W] = wb_dat_i[15:8] & PIN_MASK;
        end
      end
      if (reg_hit(wb_adr_i, IDX_OUTPUT_ACTION) && wb_sel_i[0])
      begin
        next_s.act = wb_dat_i[3:0];
      end
      if (reg_hit(wb_adr_i, IDX_INT_ENABLE) && wb_sel_i[0])
      begin
        next_s.ena = wb_dat_i[FLG_OST:FLG_CBC];
      end
    end
    next_s.rdata = '0;
    if (access && !wb_we_i)
    begin
      if (reg_hit(wb_adr_i, IDX_SOURCE_SELECT))
      begin
        next_s.rdata[REG_W-1:0] = s.sel;
      end
      else if (reg_hit(wb_adr_i, IDX_OUTPUT_ACTION))
      begin
        next_s.rdata[3:0] = s.act;
      end
      else if (reg_hit(wb_adr_i, IDX_INT_ENABLE))
      begin
        next_s.rdata[FLG_OST:FLG_CBC] = s.ena;
      end
      else if (reg_hit(wb_adr_i, IDX_STATUS_FLAGS))
      begin
        next_s.rdata[FLG_OST] = s.ost_flag;
        next_s.rdata[FLG_CBC] = s.cbc_flag;
        next_s.rdata[FLG_INT] = s.int_flag;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s <= '0;
      s.sel <= RST_SOURCE_SELECT;
      s.act <= RST_OUTPUT_ACTION;
      s.ena <= RST_INT_ENABLE;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign wb_dat_o = s.rdata;
  assign wb_ack_o = s.ack;
  assign pwm_output_a_o = s.a_val;
  assign pwm_output_a_oe_o = s.a_oe;
  assign pwm_output_b_o = s.b_val;
  assign pwm_output_b_oe_o = s.b_oe;
  assign trip_interrupt_o = s.int_flag;
  assign trip_interrupt_pulse_o = s.irq_pulse;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  property p_b_high_z;
    tripped && s.act[ACT_B_LSB +: ACT_W] == ACT_HIGH_Z
      |=> !pwm_output_b_oe_o;
  endproperty
  a_b_high_z: assert property (p_b_high_z)
    else $error("output B not released on trip");

  property p_a_force_high;
    tripped && s.act[ACT_A_LSB +: ACT_W] == ACT_FORCE_HIGH
      |=> pwm_output_a_oe_o && pwm_output_a_o;
  endproperty
  a_a_force_high: assert property (p_a_force_high)
    else $error("output A not forced high on trip");

  property p_unselected_quiet;
    !ost_hit && !s.ost_flag ##1 !ost_hit |-> !s.ost_flag;
  endproperty
  a_unselected_quiet: assert property (p_unselected_quiet)
    else $error("one-shot latch set without selected input");

  property p_ost_irq;
    s.ost_flag && !clr[FLG_OST] && s.ena[FLG_OST] && !s.int_flag
      |=> trip_interrupt_o && trip_interrupt_pulse_o ##1 !trip_interrupt_pulse_o;
  endproperty
  a_ost_irq: assert property (p_ost_irq)
    else $error("one-shot trip did not interrupt");

  property p_cbc_irq;
    s.cbc_flag && !clr[FLG_CBC] && s.ena[FLG_CBC] && !s.int_flag
      |=> trip_interrupt_o;
  endproperty
  a_cbc_irq: assert property (p_cbc_irq)
    else $error("cycle trip did not interrupt");

  property p_no_irq;
    !trig && !s.int_flag |=> !trip_interrupt_o;
  endproperty
  a_no_irq: assert property (p_no_irq)
    else $error("interrupt without enabled flag");

  property p_ost_set;
    ost_hit |=> s.ost_flag [*2];
  endproperty
  a_ost_set: assert property (p_ost_set)
    else $error("one-shot flag not latched");

  property p_ost_hold;
    s.ost_flag && clr[FLG_OST] == 1'b0 |=> s.ost_flag;
  endproperty
  a_ost_hold: assert property (p_ost_hold)
    else $error("one-shot flag dropped without clear");

  property p_cbc_release;
    s.cbc_cond && ctr_zero_i && !cbc_hit |=> !s.cbc_cond;
  endproperty
  a_cbc_release: assert property (p_cbc_release)
    else $error("cycle trip not released at zero");

  property p_cbc_keep;
    s.cbc_cond && !ctr_zero_i |=> s.cbc_cond;
  endproperty
  a_cbc_keep: assert property (p_cbc_keep)
    else $error("cycle trip released early");

  property p_single_pulse;
    s.int_flag && !clr[FLG_INT] |=> !trip_interrupt_pulse_o;
  endproperty
  a_single_pulse: assert property (p_single_pulse)
    else $error("second interrupt pulse before clear");

  property p_reserved_zero;
    wb_ack_o |-> wb_dat_o[WB_DAT_W-1:REG_W] == '0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved read bits not zero");

  property p_ack_once;
    access |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("bus ack not a single cycle");

  c_ost_trip: cover property (ost_hit ##1 s.ost_flag);
  c_cbc_cycle: cover property (s.cbc_cond ##[1:50] !s.cbc_cond);
  c_irq_refire: cover property (clr[FLG_INT] && trig
    ##1 trip_interrupt_pulse_o);
  c_hiz: cover property (tripped ##1 !pwm_output_a_oe_o);

endmodule

// File: testbench/fault_stage_model.sv
module fault_stage_model
#(
  parameter int N = 6
)
(
  // Fault requests from the bench
  input wire logic [N-1:0] fault_req_i,
  output logic [N-1:0] fault_trip_input_o,
  // Power stage side
  input wire logic out_a_i,
  input wire logic oe_a_i,
  input wire logic out_b_i,
  input wire logic oe_b_i,
  output logic pin_a_o,
  output logic pin_b_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pulled-up fault lines, low only while a fault is asserted
  assign fault_trip_input_o = ~fault_req_i;
  // Gate driver inputs pulled down when released
  assign pin_a_o = oe_a_i ? out_a_i : 1'b0;
  assign pin_b_o = oe_b_i ? out_b_i : 1'b0;
endmodule

// File: testbench/pwm_trip_zone_control_test.sv
module pwm_trip_zone_control_test
  import trip_zone_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic [5:0] fault_req = 6'h00;
  logic [5:0] fault_pins;
  logic ctr_zero = 1'b0;
  logic pwm_a = 1'b0;
  logic pwm_b = 1'b0;
  logic out_a, oe_a, out_b, oe_b, pin_a, pin_b, irq, pulse;
  int pulses = 0;
  logic [31:0] exp_q[$];
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  int seed = 48;

  always #4 sys_clk_i = ~sys_clk_i;

  pwm_trip_zone_control dut_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .fault_trip_input_i(fault_pins), .ctr_zero_i(ctr_zero),
    .pwm_a_i(pwm_a), .pwm_b_i(pwm_b), .pwm_output_a_o(out_a),
    .pwm_output_a_oe_o(oe_a), .pwm_output_b_o(out_b),
    .pwm_output_b_oe_o(oe_b), .trip_interrupt_o(irq),
    .trip_interrupt_pulse_o(pulse));

  fault_stage_model #(.N(6)) stage_u (.fault_req_i(fault_req),
    .fault_trip_input_o(fault_pins), .out_a_i(out_a), .oe_a_i(oe_a),
    .out_b_i(out_b), .oe_b_i(oe_b), .pin_a_o(pin_a), .pin_b_o(pin_b));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Read results are compared here as each ack arrives
  always @(posedge sys_clk_i)
  begin
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0)
      chk(rdat, exp_q.pop_front());
  end

  // Interrupt pulses seen so far
  always @(posedge sys_clk_i)
  begin
    if (pulse === 1'b1)
      pulses++;
  end

  always @(posedge sys_clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      complete_run();
    end
  end

  task automatic bus(input logic w, input logic [5:0] idx,
                     input logic [31:0] d);
    if (!w)
      exp_q.push_back(d);
    @(posedge sys_clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= w ? d : 32'h0;
    sel <= 4'hF;
    @(posedge sys_clk_i);
    while (ack !== 1'b1)
      @(posedge sys_clk_i);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  // Expected {drive enable, pin level} for an action code
  function automatic logic [1:0] exp_pin(input logic [1:0] code,
                                         input logic pwm);
    case (code)
      ACT_HIGH_Z: return 2'h0;
      ACT_FORCE_HIGH: return 2'h3;
      ACT_FORCE_LOW: return 2'h2;
      default: return {1'b1, pwm};
    endcase
  endfunction

  task automatic chk_pins(input logic [1:0] ca, input logic [1:0] cb);
    chk({28'h0, oe_a, pin_a, oe_b, pin_b},
        {28'h0, exp_pin(ca, pwm_a), exp_pin(cb, pwm_b)});
  endtask

  initial
  begin
    wait_clk(4);
    rst_n_i <= 1'b1;
    bus(1'b0, IDX_OUTPUT_ACTION, 32'h0);
    bus(1'b0, IDX_STATUS_FLAGS, 32'h0);
    bus(1'b0, 6'h01, 32'h0);
    bus(1'b1, IDX_OUTPUT_ACTION, 32'hFFFF);
    bus(1'b0, IDX_OUTPUT_ACTION, 32'h000F);
    bus(1'b1, IDX_INT_ENABLE, 32'hFFFF);
    bus(1'b0, IDX_INT_ENABLE, 32'h0006);
    bus(1'b1, IDX_INT_ENABLE, 32'h0);
    bus(1'b1, IDX_SOURCE_SELECT, 32'hFFFF);
    bus(1'b0, IDX_SOURCE_SELECT, 32'h3F3F);
    bus(1'b1, IDX_SOURCE_SELECT, 32'h0201);
    $display("test registers done");
    fault_req[5] <= 1'b1;
    wait_clk(8);
    fault_req[5] <= 1'b0;
    bus(1'b0, IDX_STATUS_FLAGS, 32'h0);
    for (int c = 0; c < 4; c++)
    begin
      pwm_a <= 1'($random(seed));
      pwm_b <= 1'($random(seed));
      bus(1'b1, IDX_OUTPUT_ACTION, {28'h0, 2'(3 - c), 2'(c)});
      fault_req[1] <= 1'b1;
      wait_clk(8);
      fault_req[1] <= 1'b0;
      wait_clk(4);
      chk_pins(2'(c), 2'(3 - c));
      bus(1'b0, IDX_STATUS_FLAGS, 32'h4);
      bus(1'b1, IDX_STATUS_FLAGS, 32'h0);
      bus(1'b0, IDX_STATUS_FLAGS, 32'h4);
      bus(1'b1, IDX_FLAG_CLEAR, 32'h4);
      bus(1'b0, IDX_STATUS_FLAGS, 32'h0);
      wait_clk(2);
      chk_pins(ACT_NO_ACTION, ACT_NO_ACTION);
    end
    chk({31'h0, irq}, 32'h0);
    chk(pulses, 32'h0);
    $display("test one-shot actions done");
    bus(1'b1, IDX_OUTPUT_ACTION, 32'h6);
    bus(1'b1, IDX_INT_ENABLE, 32'h4);
    fault_req[1] <= 1'b1;
    wait_clk(8);
    fault_req[1] <= 1'b0;
    chk({31'h0, irq}, 32'h1);
    chk(pulses, 32'h1);
    bus(1'b0, IDX_STATUS_FLAGS, 32'h5);
    bus(1'b1, IDX_FLAG_CLEAR, 32'h1);
    wait_clk(3);
    chk({31'h0, irq}, 32'h1);
    chk(pulses, 32'h2);
    bus(1'b1, IDX_FLAG_CLEAR, 32'h5);
    wait_clk(3);
    chk({31'h0, irq}, 32'h0);
    chk(pulses, 32'h2);
    bus(1'b1, IDX_INT_ENABLE, 32'h2);
    fault_req[1] <= 1'b1;
    wait_clk(8);
    fault_req[1] <= 1'b0;
    chk({31'h0, irq}, 32'h0);
    chk(pulses, 32'h2);
    // Let the released pin pass the synchroniser, else the trip beats the clear
    wait_clk(4);
    bus(1'b1, IDX_FLAG_CLEAR, 32'h4);
    $display("test interrupt done");
    fault_req[0] <= 1'b1;
    wait_clk(8);
    fault_req[0] <= 1'b0;
    chk({31'h0, irq}, 32'h1);
    chk(pulses, 32'h3);
    chk_pins(ACT_FORCE_LOW, ACT_FORCE_HIGH);
    wait_clk(4);
    chk_pins(ACT_FORCE_LOW, ACT_FORCE_HIGH);
    ctr_zero <= 1'b1;
    wait_clk(1);
    ctr_zero <= 1'b0;
    wait_clk(3);
    chk_pins(ACT_NO_ACTION, ACT_NO_ACTION);
    bus(1'b0, IDX_STATUS_FLAGS, 32'h3);
    bus(1'b1, IDX_FLAG_CLEAR, 32'h3);
    bus(1'b0, IDX_STATUS_FLAGS, 32'h0);
    $display("test cycle-by-cycle done");
    wait_clk(2);
    complete_run();
  end
endmodule
